// ---- logic/ric_defines.svh ----
// Purpose: constants for the register integrity checker
// Assumes: 200 MHz clk_sys
// Notes: offsets are word addresses of the plain register port
// Function
// - status, data, error, counter registers not protected
// - map check repeats every 1/2400 second
// - recalc reference after writes and calibrations
// - recalc on standby after single conversion
// - recalc when continuous readout is cleared
// - map check runs only while enabled
// - map mismatch sets map fail flag
// - registers load defaults from ROM at power-up
// - ROM CRC computed at power-up
// - ROM check enabled by bit; failure sets flag
// - keep internal clock in standby when ROM check on
// - 8-bit CRC, polynomial x^8+x^2+x+1
// - eight zero bits appended before division
// - remainder is checksum, zero init, no inversion
`ifndef RIC_DEFINES_SVH
`define RIC_DEFINES_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define RIC_ADDR_CTRL    4'h0
`define RIC_ADDR_ERR_EN  4'h1
`define RIC_ADDR_ERR     4'h2
`define RIC_ADDR_MASK    4'h3
`define RIC_ADDR_STATUS  4'h4
`define RIC_ADDR_CNT     4'h5
`define RIC_ADDR_CFG0    4'h8
// ----------------------------------------
// fields and values
// ----------------------------------------
`define RIC_BIT_MAP_EN   0
`define RIC_BIT_ROM_EN   1
`define RIC_BIT_CONT_RD  0
`define RIC_BIT_MAP_ERR  0
`define RIC_BIT_ROM_ERR  1
`define RIC_POLY         8'h07
`define RIC_ERR_EN_RST   8'h00
// default-value store, byte 0 lowest; top byte zeroes the residue
`define RIC_ROM_IMAGE    64'h6100_0086_0040_0001
// ----------------------------------------
// timing
// ----------------------------------------
`define RIC_CLK_HZ       200000000
`define RIC_CHECK_RATE   2400
`define RIC_PERIOD_CYC   (`RIC_CLK_HZ / `RIC_CHECK_RATE)
`endif

// ---- logic/ric_pkg.sv ----
// Purpose: types for the register integrity checker
// Assumes: nothing
// Notes: states Gray coded along the walk
package ric_pkg;
  typedef enum logic [1:0] {
    RIC_IDLE = 2'b00,
    RIC_WALK = 2'b01,
    RIC_DONE = 2'b11
  } ric_state_t;
  typedef enum logic [1:0] {
    RIC_JOB_ROM   = 2'b00,
    RIC_JOB_REF   = 2'b01,
    RIC_JOB_CHECK = 2'b10
  } ric_job_t;
endpackage

// ---- logic/ric_checker.sv ----
// Purpose: CRC integrity check over config map and default ROM
// Assumes: register port on clk_sys; event inputs on clk_sys
// Notes: eight 8-bit config registers are protected
//
// The implementer's own choices: the strobed register port and the register addresses.
`timescale 1ns/10ps
`include "ric_defines.svh"
module ric_checker #(
  parameter int NREG       = 8,
  parameter int PERIOD_CYC = `RIC_PERIOD_CYC
) (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  // register port
  input  wire logic [3:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  // converter events
  input  wire logic       calib_done,
  input  wire logic       single_standby,
  input  wire logic       int_clk_sel,
  input  wire logic       standby,
  // outputs
  output logic            int_clk_keep,
  output logic            irq
);
  // default-value store, constant table
  localparam logic [NREG-1:0][7:0] ROM = `RIC_ROM_IMAGE;
  localparam int PW = $clog2(PERIOD_CYC + 1);
  localparam logic [PW-1:0] PLAST = PW'(PERIOD_CYC - 1);

  typedef struct packed {
    logic [NREG-1:0][7:0] cfg;
    logic [7:0]           err_en;
    logic [1:0]           err;
    logic [1:0]           mask;
    logic                 cont_rd;
    logic [7:0]           ref_crc;
    logic [7:0]           crc;
    logic [2:0]           idx;
    logic [3:0]           bitn;
    logic [PW-1:0]        tick;
    logic                 pend;
    logic                 booted;
    ric_pkg::ric_state_t  st;
    ric_pkg::ric_job_t    job;
    logic [7:0]           rdata;
  } ric_st_t;

  ric_st_t r;
  ric_st_t next_r;
  logic [7:0] cur_byte;
  logic       fb;
  logic       din;
  logic [1:0] ev;

  // byte under the walk; ROM job reads the store
  always_comb begin
    if (r.job == ric_pkg::RIC_JOB_ROM) begin
      cur_byte = ROM[r.idx];
    end else begin
      cur_byte = r.cfg[r.idx];
    end
  end

  // augmented division: data bits msb first, then eight zero bits shift in
  assign din = (r.bitn < 4'd8) ? cur_byte[3'(7 - r.bitn)] : 1'b0;
  // bit leaving the top decides whether the polynomial is xored in
  assign fb = r.crc[7];

  always_comb begin
    next_r = r;
    ev = 2'b00;
    next_r.rdata = 8'h00;
    // register port writes; protected writes require new reference
    if (wr) begin
      if (addr == `RIC_ADDR_ERR_EN) begin
        next_r.err_en = wdata;
      end else if (addr == `RIC_ADDR_ERR) begin
        next_r.err = r.err & ~wdata[1:0];
      end else if (addr == `RIC_ADDR_MASK) begin
        next_r.mask = wdata[1:0];
      end else if (addr == `RIC_ADDR_CTRL) begin
        next_r.cont_rd = wdata[`RIC_BIT_CONT_RD];
        if (r.cont_rd && !wdata[`RIC_BIT_CONT_RD]) begin
          next_r.pend = 1'b1;
        end
      end else if (addr >= `RIC_ADDR_CFG0) begin
        next_r.cfg[addr[2:0]] = wdata;
        next_r.pend = 1'b1;
      end
    end
    // reads; error, status, counter outside the protected set
    if (rd) begin
      if (addr == `RIC_ADDR_CTRL) begin
        next_r.rdata = {7'h00, r.cont_rd};
      end else if (addr == `RIC_ADDR_ERR_EN) begin
        next_r.rdata = r.err_en;
      end else if (addr == `RIC_ADDR_ERR) begin
        next_r.rdata = {6'h00, r.err};
      end else if (addr == `RIC_ADDR_MASK) begin
        next_r.rdata = {6'h00, r.mask};
      end else if (addr == `RIC_ADDR_STATUS) begin
        next_r.rdata = {5'h00, r.booted, r.st};
      end else if (addr == `RIC_ADDR_CNT) begin
        next_r.rdata = 8'(r.tick);
      end else if (addr >= `RIC_ADDR_CFG0) begin
        next_r.rdata = r.cfg[addr[2:0]];
      end
    end
    if (calib_done || single_standby) begin
      next_r.pend = 1'b1;
    end
    // periodic tick while map check enabled
    if (r.err_en[`RIC_BIT_MAP_EN]) begin
      next_r.tick = (r.tick == PLAST) ? '0 : PW'(r.tick + 1'b1);
    end else begin
      next_r.tick = '0;
    end
    // walker
    case (r.st)
      ric_pkg::RIC_IDLE: begin
        next_r.crc = 8'h00;
        next_r.idx = 3'd0;
        next_r.bitn = 4'd0;
        if (!r.booted) begin
          next_r.job = ric_pkg::RIC_JOB_ROM;
          next_r.st = ric_pkg::RIC_WALK;
        end else if (r.pend || next_r.pend) begin
          next_r.pend = 1'b0;
          next_r.job = ric_pkg::RIC_JOB_REF;
          next_r.st = ric_pkg::RIC_WALK;
        end else if (r.err_en[`RIC_BIT_MAP_EN] && r.tick == PLAST) begin
          next_r.job = ric_pkg::RIC_JOB_CHECK;
          next_r.st = ric_pkg::RIC_WALK;
        end
      end
      ric_pkg::RIC_WALK: begin
        next_r.crc = {r.crc[6:0], din} ^ (fb ? `RIC_POLY : 8'h00);
        if (r.idx == 3'(NREG - 1) && r.bitn == 4'd15) begin
          next_r.st = ric_pkg::RIC_DONE;
        end else if (r.idx != 3'(NREG - 1) && r.bitn == 4'd7) begin
          next_r.bitn = 4'd0;
          next_r.idx = r.idx + 3'd1;
        end else begin
          next_r.bitn = r.bitn + 4'd1;
        end
      end
      default: begin
        // compare or store result
        if (r.job == ric_pkg::RIC_JOB_ROM) begin
          next_r.booted = 1'b1;
          next_r.cfg = ROM;
          next_r.ref_crc = r.crc;
          if (r.err_en[`RIC_BIT_ROM_EN] && r.crc != 8'h00) begin
            ev[1] = 1'b1;
          end
        end else if (r.job == ric_pkg::RIC_JOB_REF) begin
          next_r.ref_crc = r.crc;
        end else if (r.err_en[`RIC_BIT_MAP_EN] && !r.pend && r.crc != r.ref_crc) begin
          // a write during the walk leaves a mixed sum; the pending recalc covers it
          ev[0] = 1'b1;
        end
        next_r.st = ric_pkg::RIC_IDLE;
      end
    endcase
    // set wins over clear
    next_r.err = next_r.err | ev;
  end

  // state register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign rdata = r.rdata;
  assign irq = |(r.err & r.mask);
  assign int_clk_keep = r.err_en[`RIC_BIT_ROM_EN] & int_clk_sel & standby;
endmodule // ric_checker

// ---- verif/ric_sva.sv ----
// Purpose: port checks on ric_checker
// Assumes: enable register resets to zero
// Notes: bind at the foot
`timescale 1ns/10ps
module ric_sva (
  // watched ports
  input wire logic       clk_sys,
  input wire logic       rst_n,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire logic       int_clk_sel,
  input wire logic       standby,
  input wire logic       int_clk_keep,
  input wire logic       irq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // enable bits ever written since reset
  logic [1:0] en_seen;
  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n) en_seen <= 2'h0;
    else if (wr && addr == 4'h1) en_seen <= en_seen | wdata[1:0];
  // config write, then its read
  sequence s_cfg_wr_rd;
    wr && addr == 4'h8 ##2 rd && addr == 4'h8;
  endsequence
  a_keep_in_standby: assert property (int_clk_keep |-> int_clk_sel && standby)
    else $error("keep outside standby");
  a_keep_needs_rom: assert property (!en_seen[1] |-> !int_clk_keep)
    else $error("keep without rom check");
  a_map_flag_off: assert property (rd && addr == 4'h2 && !en_seen[0] |=> !rdata[0])
    else $error("map flag while off");
  a_rom_flag_off: assert property (rd && addr == 4'h2 && !en_seen[1] |=> !rdata[1])
    else $error("rom flag while off");
  a_cfg_read_back: assert property (s_cfg_wr_rd |=> rdata == $past(wdata, 3))
    else $error("config read back differs");
  a_rdata_quiet: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data outside slot");
  a_unmapped_zero: assert property (rd && addr == 4'h7 |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  a_irq_masked: assert property (wr && addr == 4'h3 && wdata == 8'h00 ##1 !wr |=> !irq)
    else $error("irq with zero mask");
endmodule // ric_sva
bind ric_checker ric_sva u_sva (.clk_sys, .rst_n, .addr, .wdata, .wr, .rd, .rdata,
  .int_clk_sel, .standby, .int_clk_keep, .irq);

// ---- verif/ric_host.sv ----
// Purpose: host model on the register port
// Assumes: one access at a time
// Notes: released lines show inverted values
`timescale 1ns/10ps
module ric_host (
  // register port
  input  wire logic       clk_sys,
  input  wire logic [7:0] rdata,
  output logic      [3:0] addr,
  output logic      [7:0] wdata,
  output logic            wr,
  output logic            rd
);
  initial {addr, wdata, wr, rd} = 14'h0000;
  // one-cycle write strobe
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    {addr, wdata, wr} <= {a, d, 1'b1};
    @(posedge clk_sys);
    {addr, wdata, wr} <= {~a, ~d, 1'b0};
  endtask
  // one-cycle read strobe, data taken next cycle
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    {addr, rd} <= {a, 1'b1};
    @(posedge clk_sys);
    {addr, rd} <= {~a, 1'b0};
    #1 d = rdata;
  endtask
endmodule // ric_host

// ---- verif/testbench.sv ----
// Purpose: self-checking bench for ric_checker
// Assumes: period shortened to 200 cycles
// Notes: config data from an lfsr seeded with 78
`timescale 1ns/10ps
`include "ric_defines.svh"
module testbench;
  logic       clk_sys = 1'b0;
  logic       rst_n = 1'b0;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, rv, lf;
  logic       wr, rd, int_clk_keep, irq;
  logic       calib_done = 1'b0, single_standby = 1'b0;
  logic       int_clk_sel = 1'b0, standby = 1'b0;
  int         err_count = 0, checks_done = 0;
  localparam logic [7:0][7:0] ROM_IMG = `RIC_ROM_IMAGE;
  always #2.5 clk_sys = ~clk_sys;
  ric_host u_host (.clk_sys, .rdata, .addr, .wdata, .wr, .rd);
  ric_checker #(.PERIOD_CYC(200)) dut (.clk_sys, .rst_n, .addr, .wdata, .wr, .rd, .rdata,
    .calib_done, .single_standby, .int_clk_sel, .standby, .int_clk_keep, .irq);
  // next lfsr state
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // residue of an eight-byte image, byte 0 first, msb first, poly x^8+x^2+x+1
  function automatic logic [7:0] crc8(input logic [63:0] img);
    logic [7:0] c;
    c = 8'h00;
    for (int k = 0; k < 64; k++) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ img[8 * (k / 8) + 7 - k % 8]) ? 8'h07 : 8'h00);
    end
    return c;
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic conclude;
    $display("errors=%0d checks=%0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // run limit
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_count++;
    conclude();
  end
  initial begin
    lf = 8'h4e;
    rv = 8'h00;
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    for (int i = 0; i < 100 && rv[2] !== 1'b1; i++) u_host.rd_reg(4'h4, rv);
    if (rv[2] !== 1'b1) begin
      err_count++;
      conclude();
    end
    u_host.rd_reg(4'h2, rv);
    check(rv, 8'h00);
    // random config stored, then a hole in the map
    for (int i = 8; i < 16; i++) begin
      lf = lfsr(lf);
      u_host.wr_reg(i[3:0], lf);
      u_host.rd_reg(i[3:0], rv);
      check(rv, lf);
    end
    u_host.rd_reg(4'h7, rv);
    check(rv, 8'h00);
    // map check on, every recalc trigger, no flag may follow
    u_host.wr_reg(4'h1, 8'h01);
    u_host.wr_reg(4'h3, 8'h03);
    for (int i = 0; i < 4; i++) begin
      lf = lfsr(lf);
      u_host.wr_reg(4'h0, {7'h00, i[0]});
      u_host.wr_reg(4'h8 + {2'h0, i[1:0]}, lf);
      @(posedge clk_sys) {calib_done, single_standby} <= {i[0], i[1]};
      @(posedge clk_sys) {calib_done, single_standby} <= 2'h0;
      repeat (450) @(posedge clk_sys);
      u_host.rd_reg(4'h2, rv);
      check(rv, 8'h00);
      check({7'h00, irq}, 8'h00);
    end
    // clock hold in standby with rom check on, then off
    u_host.wr_reg(4'h3, 8'h00);
    u_host.wr_reg(4'h1, 8'h02);
    for (int m = 0; m < 8; m++) begin
      if (m == 4) u_host.wr_reg(4'h1, 8'h00);
      @(posedge clk_sys) {int_clk_sel, standby} <= m[1:0];
      @(negedge clk_sys) check({7'h00, int_clk_keep}, {7'h00, m < 4 && m[1] && m[0]});
    end
    // mid-run reset, rom check enabled while the boot walk runs
    @(posedge clk_sys) rst_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    u_host.wr_reg(4'h1, 8'h02);
    rv = 8'h00;
    for (int i = 0; i < 100 && rv[2] !== 1'b1; i++) u_host.rd_reg(4'h4, rv);
    check({7'h00, rv[2]}, 8'h01);
    u_host.rd_reg(4'h2, rv);
    check(rv, {6'h00, crc8(ROM_IMG) != 8'h00, 1'b0});
    u_host.rd_reg(4'h8, rv);
    check(rv, ROM_IMG[0]);
    u_host.rd_reg(4'hf, rv);
    check(rv, ROM_IMG[7]);
    conclude();
  end
endmodule // testbench
